// *** wdtkr_link_if.sv ***
// Carrier between the watchdog core and its prescaler and reset stretcher.
// Assumes all parties run on the one system clock.
`default_nettype none

interface wdtkr_link_if;
	logic [2:0] sel;
	logic restart;
	logic tick;
	logic fire;
	logic busy;
	modport core (output sel, output restart, input tick,
		output fire, input busy);
	modport pre (input sel, input restart, output tick);
	modport rst (input fire, output busy);
endinterface : wdtkr_link_if

`default_nettype wire

// *** wdtkr_pkg.sv ***
// Constants, register map and state types of the keyed watchdog.
// Assumes a single 40 MHz clock and an APB master with 32-bit data.
//
// Overview of operation
// [RQ1] Any reset selects fastest rate, base clock/512
// [RQ2] Counter starts at reset release, runs freely
// [RQ3] Counter overflow without service forces system reset
// [RQ4] Correct key write clears the counter
// [RQ5] Wrong key write forces system reset immediately
// [RQ6] Control writes need check pattern 101
// [RQ7] Disable bit works only with permit bit set
// [RQ8] Permit bit clear keeps watchdog running always
// [RQ9] Seven overflow rates from three-bit prescale field
// [RQ10] Prescale decode: 00X/1, then 2 to 64
// [RQ11] Registers are 8 bits, upper bytes zero
// [RQ12] Three control registers from base 7020h
// [RQ13] Counter is 8 bits, overflow on wrap
// [RQ14] Correct key values are design parameters
`default_nettype none

package wdtkr_pkg;
	// ==========================================================
	// Register map, byte addresses
	localparam logic [15:0] WDT_BASE = 16'h7020;
	localparam logic [15:0] OFS_COUNT = 16'h0000;
	localparam logic [15:0] OFS_KEY = 16'h0004;
	localparam logic [15:0] OFS_CTRL = 16'h0008;
	localparam logic [15:0] OFS_SCS2 = 16'h000C;
	localparam logic [15:0] OFS_IRQ_STAT = 16'h0010;
	localparam logic [15:0] OFS_IRQ_EN = 16'h0014;
	localparam logic [15:0] OFS_IRQ_CLR = 16'h0018;

	// ==========================================================
	// Field positions and values
	localparam int CTRL_DIS_BIT = 6;
	localparam int CTRL_CHK_HI = 5;
	localparam int CTRL_CHK_LO = 3;
	localparam logic [2:0] CTRL_CHK_PATTERN = 3'h5;
	localparam int SCS2_PERMIT_BIT = 5;
	localparam int IRQ_OVF = 0;
	localparam int IRQ_BADKEY = 1;
	localparam int IRQ_BADCHK = 2;
	localparam logic [2:0] PS_RESET = 3'h0;
	localparam logic [7:0] CNT_RESET = 8'h00;

	// ==========================================================
	// Counts of cycles
	localparam logic [8:0] BASE_LAST = 9'h1FF;
	localparam logic [3:0] RST_PULSE_CYC = 4'h8;

	// ==========================================================
	// State types
	typedef struct packed {
		logic [7:0] cnt;
		logic [2:0] ps;
		logic dis;
		logic permit;
		logic [2:0] ist;
		logic [2:0] ien;
		logic [31:0] rdata;
	} wdtkr_top_st_t;

	typedef struct packed {
		logic [8:0] base;
		logic [5:0] sub;
	} wdtkr_pre_st_t;

	typedef struct packed {
		logic [3:0] left;
	} wdtkr_rst_st_t;
endpackage : wdtkr_pkg

`default_nettype wire

// *** wdtkr_prescale.sv ***
// Prescaler: system clock /512 base, then /1 to /64 per select.
// Assumes select is held steady by the core between writes.
`default_nettype none

module wdtkr_prescale
	import wdtkr_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_reset,
	wdtkr_link_if.pre lnk
);
	wdtkr_pre_st_t s_q;
	wdtkr_pre_st_t s_d;

	// ==========================================================
	// Select decode into a mask of low sub-divider bits
	function automatic logic [5:0] div_mask(input logic [2:0] sel);
		unique case (sel)
			3'h0, 3'h1: div_mask = 6'h00; // RQ10
			3'h2: div_mask = 6'h01;
			3'h3: div_mask = 6'h03;
			3'h4: div_mask = 6'h07;
			3'h5: div_mask = 6'h0F;
			3'h6: div_mask = 6'h1F;
			3'h7: div_mask = 6'h3F;
		endcase
	endfunction : div_mask

	// Tick once per 512 * N clocks; a mask keeps it one comparator
	assign lnk.tick = (s_q.base == BASE_LAST) &&
		((s_q.sub & div_mask(lnk.sel)) == div_mask(lnk.sel)); // RQ9

	// ==========================================================
	// Next state
	always_comb begin
		s_d = s_q;
		s_d.base = 9'(s_q.base + 9'h001);
		if (s_q.base == BASE_LAST) begin
			s_d.sub = 6'(s_q.sub + 6'h01);
		end
		if (lnk.restart) begin
			s_d = '0; // RQ1
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// ==========================================================
	// Checks
	property p_tick_base;
		@(posedge i_clk) disable iff (i_reset)
		lnk.tick |-> s_q.base == BASE_LAST;
	endproperty
	a_tick_base: assert property (p_tick_base) // RQ1
		else $error("tick off the 512 boundary");
endmodule : wdtkr_prescale

`default_nettype wire

// *** wdtkr_rststretch.sv ***
// Stretches a reset request into a fixed-length system reset level.
// Assumes requests may repeat; a new one restarts the length.
`default_nettype none

module wdtkr_rststretch
	import wdtkr_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_reset,
	wdtkr_link_if.rst lnk
);
	wdtkr_rst_st_t s_q;
	wdtkr_rst_st_t s_d;

	assign lnk.busy = (s_q.left != 4'h0);

	// ==========================================================
	// Count down the pulse, reload on every request
	always_comb begin
		s_d = s_q;
		if (lnk.fire) begin
			s_d.left = RST_PULSE_CYC;
		end else if (s_q.left != 4'h0) begin
			s_d.left = 4'(s_q.left - 4'h1);
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
endmodule : wdtkr_rststretch

`default_nettype wire

// *** wdtkr_tb_top.sv ***
// Self-checking bench for the keyed watchdog top, driven through APB.
// Assumes wdtkr_pkg and the design files are compiled before this one.
`default_nettype none

module tb_top
	import wdtkr_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	// ==========================================================
	// Signals and design
	logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, wd_rst, irq;
	logic [15:0] paddr = 16'h0000;
	logic [31:0] pwdata = 32'h0000_0000, prdata;
	logic pready, pslverr, e;
	logic [31:0] r;
	int error_cnt = 0, tests_run = 0, cyc = 0;
	// Keys as the design's defaults; either one services the counter
	localparam logic [7:0] KEY_A_V = 8'h55;
	localparam logic [7:0] KEY_B_V = 8'hAA;
	`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin \
error_cnt++; $display("mismatch %s exp %h got %h", nm, ex, got); end end

	wdtkr_top i_dut (.I_SYS_CLK(clk), .I_RESET(rst), .I_PSEL(psel),
		.I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
		.I_PSTRB(4'hF), .O_PRDATA(prdata), .O_PREADY(pready),
		.O_PSLVERR(pslverr), .O_WD_RESET(wd_rst), .O_IRQ(irq));

	// ==========================================================
	// Clock and hang guard; 40000 cycles is well over the planned run
	always #12.5 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			error_cnt++;
			wrap_up();
		end
	end

	// ==========================================================
	// Bus and shared tasks
	// One APB transfer; waits for ready with a bound, no fixed latency
	task automatic apb(input logic w, input logic [15:0] ofs,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1;
		pwr <= w;
		paddr <= WDT_BASE + ofs;
		pwdata <= d;
		@(posedge clk);
		pen <= 1;
		forever begin
			@(posedge clk);
			if (pready === 1'b1) break;
			n++;
			if (n > 16) begin
				error_cnt++;
				wrap_up();
			end
		end
		r = prdata;
		e = pslverr;
		psel <= 0;
		pen <= 0;
	endtask : apb

	// Counts reset-out cycles after the write that caused it;
	// called in the time step of the taking edge, so sample after it
	task automatic pulse_check(input string nm);
		int hi;
		hi = 0;
		for (int i = 0; i < 12; i++) begin
			#1;
			if (i == 0) `CHK(nm, 1'b1, wd_rst)
			hi += (wd_rst === 1'b1);
			@(posedge clk);
		end
		`CHK(nm, 8, hi)
	endtask : pulse_check

	// ==========================================================
	// Scenarios
	task automatic t_reset_map();
		apb(0, OFS_CTRL, 0);
		`CHK("ctrl_rst", 32'h0000_0000, r)
		apb(0, OFS_COUNT, 0);
		`CHK("cnt_rst", 32'h0000_0000, r)
		apb(0, OFS_IRQ_STAT, 0);
		`CHK("stat_rst", 32'h0000_0000, r)
		apb(0, 16'h0040, 0);
		`CHK("unmapped", 1'b1, e)
	endtask : t_reset_map

	task automatic t_run_key();
		repeat (700) @(posedge clk);
		apb(0, OFS_COUNT, 0);
		`CHK("cnt_free", 32'h0000_0001, r)
		apb(1, OFS_KEY, {24'h0000_00, KEY_A_V});
		apb(0, OFS_COUNT, 0);
		`CHK("key_a", 32'h0000_0000, r)
		repeat (1100) @(posedge clk);
		apb(1, OFS_KEY, {24'h0000_00, KEY_B_V});
		apb(0, OFS_COUNT, 0);
		`CHK("key_b", 32'h0000_0000, r)
		`CHK("no_rst", 1'b0, wd_rst)
	endtask : t_run_key

	// Rates /1 (low bit ignored), /2, /4; upper bytes of the write dropped
	task automatic t_rates();
		for (int p = 1; p < 4; p++) begin
			apb(1, OFS_CTRL, 32'hA5A5_A528 | p);
			apb(0, OFS_CTRL, 0);
			`CHK("ctrl_rd", p, r)
			apb(1, OFS_KEY, {24'h0000_00, KEY_A_V});
			repeat (1280 << (p - 1)) @(posedge clk);
			apb(0, OFS_COUNT, 0);
			`CHK("rate", 1'b1, r[7:0] == 2 || r[7:0] == 3)
		end
	endtask : t_rates

	task automatic t_disable();
		for (int pm = 0; pm < 2; pm++) begin
			apb(1, OFS_SCS2, pm << SCS2_PERMIT_BIT);
			apb(1, OFS_CTRL, 32'h0000_0068);
			apb(1, OFS_KEY, {24'h0000_00, KEY_A_V});
			repeat (1100) @(posedge clk);
			apb(0, OFS_COUNT, 0);
			`CHK("dis", pm == 0, r != 0)
		end
		apb(1, OFS_SCS2, 0);
		apb(1, OFS_CTRL, 32'h0000_0028);
	endtask : t_disable

	// Wrong key with irq enabled, then wrong check pattern masked
	task automatic t_faults();
		apb(1, OFS_IRQ_EN, 32'h0000_0002);
		apb(1, OFS_KEY, 32'h0000_0012);
		pulse_check("badkey");
		`CHK("irq_on", 1'b1, irq)
		apb(0, OFS_IRQ_STAT, 0);
		`CHK("stat_key", 32'h0000_0002, r)
		apb(1, OFS_IRQ_CLR, 32'h0000_0002);
		#1;
		`CHK("irq_clr", 1'b0, irq)
		apb(1, OFS_CTRL, 32'h0000_002F);
		apb(1, OFS_CTRL, 32'h0000_0030);
		pulse_check("badchk");
		`CHK("irq_mask", 1'b0, irq)
		apb(0, OFS_IRQ_STAT, 0);
		`CHK("stat_chk", 32'h0000_0004, r)
		apb(0, OFS_CTRL, 0);
		`CHK("ps_after", 32'h0000_0000, r)
	endtask : t_faults

	// ==========================================================
	// Verdict
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : wrap_up

	initial begin
		repeat (4) @(posedge clk);
		rst <= 0;
		t_reset_map();
		t_run_key();
		t_rates();
		t_disable();
		t_faults();
		wrap_up();
	end
endmodule : tb_top

`default_nettype wire

// *** wdtkr_top.sv ***
// Keyed watchdog: APB registers, 8-bit counter, reset and interrupt.
// Assumes APB4 master on the system clock; reset out feeds system reset.
//
// Local design decisions: the APB interface to the registers and the register offsets.
`default_nettype none

module wdtkr_top
	import wdtkr_pkg::*;
#(
	parameter logic [7:0] KEY_A = 8'h55,
	parameter logic [7:0] KEY_B = 8'hAA
)
(
	input wire logic I_SYS_CLK,
	input wire logic I_RESET,
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [15:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	input wire logic [3:0] I_PSTRB,
	output logic [31:0] O_PRDATA,
	output logic O_PREADY,
	output logic O_PSLVERR,
	output logic O_WD_RESET,
	output logic O_IRQ
);
	wdtkr_top_st_t s_q;
	wdtkr_top_st_t s_d;
	wdtkr_link_if lnk();
	logic wr;
	logic hit;
	logic running;
	logic key_ok;
	logic ev_ovf;
	logic ev_key;
	logic ev_chk;
	logic [2:0] ofs;

	// ==========================================================
	// Address decode into register slots, 7 means unmapped
	function automatic logic [2:0] reg_slot(input logic [15:0] a);
		logic [15:0] r;
		r = 16'(a - WDT_BASE);
		unique case (r)
			OFS_COUNT: reg_slot = 3'h0; // RQ12
			OFS_KEY: reg_slot = 3'h1;
			OFS_CTRL: reg_slot = 3'h2;
			OFS_SCS2: reg_slot = 3'h3;
			OFS_IRQ_STAT: reg_slot = 3'h4;
			OFS_IRQ_EN: reg_slot = 3'h5;
			OFS_IRQ_CLR: reg_slot = 3'h6;
			default: reg_slot = 3'h7;
		endcase
	endfunction : reg_slot

	// ==========================================================
	// Submodules
	wdtkr_prescale u_pre (
		.i_clk(I_SYS_CLK),
		.i_reset(I_RESET),
		.lnk(lnk.pre)
	);

	wdtkr_rststretch u_rst (
		.i_clk(I_SYS_CLK),
		.i_reset(I_RESET),
		.lnk(lnk.rst)
	);

	// ==========================================================
	// Bus handshake; zero wait states keeps the slave simple
	assign ofs = reg_slot(I_PADDR);
	assign hit = (ofs != 3'h7);
	assign wr = I_PSEL && I_PENABLE && I_PWRITE && I_PSTRB[0] && hit;
	assign O_PREADY = 1'b1;
	assign O_PSLVERR = I_PSEL && I_PENABLE && !hit;
	assign O_PRDATA = s_q.rdata;
	assign O_WD_RESET = lnk.busy;
	assign O_IRQ = |(s_q.ist & s_q.ien);

	// Permit bit gates the disable bit; no permit, no stop
	assign running = !lnk.busy && !(s_q.dis && s_q.permit); // RQ7 RQ8
	assign key_ok = (I_PWDATA[7:0] == KEY_A) ||
		(I_PWDATA[7:0] == KEY_B); // RQ14

	// ==========================================================
	// Reset causes from counter and register writes
	always_comb begin
		ev_ovf = running && lnk.tick && (s_q.cnt == 8'hFF); // RQ3 RQ13
		ev_key = wr && (ofs == 3'h1) && !key_ok; // RQ5
		ev_chk = wr && (ofs == 3'h2) &&
			(I_PWDATA[CTRL_CHK_HI:CTRL_CHK_LO] !=
			CTRL_CHK_PATTERN); // RQ6
	end

	assign lnk.fire = ev_ovf || ev_key || ev_chk;
	assign lnk.restart = lnk.busy;
	assign lnk.sel = s_q.ps;

	// ==========================================================
	// Next state of counter, registers and read data
	always_comb begin
		s_d = s_q;
		// Counting starts on its own once reset is gone
		if (running && lnk.tick) begin
			s_d.cnt = 8'(s_q.cnt + 8'h01); // RQ2 RQ13
		end
		if (wr) begin
			unique case (ofs)
				3'h1: begin
					if (key_ok) begin
						s_d.cnt = CNT_RESET; // RQ4
					end
				end
				3'h2: begin
					if (!ev_chk) begin
						s_d.ps = I_PWDATA[2:0]; // RQ9
						s_d.dis = I_PWDATA[CTRL_DIS_BIT]; // RQ7
					end
				end
				3'h3: s_d.permit = I_PWDATA[SCS2_PERMIT_BIT];
				3'h5: s_d.ien = I_PWDATA[2:0];
				3'h6: s_d.ist = s_q.ist & ~I_PWDATA[2:0];
				default: begin
				end
			endcase
		end
		// Event set after clear, so a coinciding event survives
		s_d.ist[IRQ_OVF] = s_d.ist[IRQ_OVF] | ev_ovf;
		s_d.ist[IRQ_BADKEY] = s_d.ist[IRQ_BADKEY] | ev_key;
		s_d.ist[IRQ_BADCHK] = s_d.ist[IRQ_BADCHK] | ev_chk;
		// System reset under way: back to fastest rate, counter clear
		if (lnk.busy) begin
			s_d.cnt = CNT_RESET; // RQ1
			s_d.ps = PS_RESET; // RQ1
			s_d.dis = 1'b0;
			s_d.permit = 1'b0;
		end
		// Read data captured in setup phase, upper bytes stay zero
		if (I_PSEL && !I_PENABLE) begin
			s_d.rdata = 32'h0000_0000; // RQ11
			unique case (ofs)
				3'h0: s_d.rdata[7:0] = s_q.cnt;
				3'h2: s_d.rdata[7:0] = {1'b0, s_q.dis, 3'h0, s_q.ps};
				3'h3: s_d.rdata[SCS2_PERMIT_BIT] = s_q.permit;
				3'h4: s_d.rdata[2:0] = s_q.ist;
				3'h5: s_d.rdata[2:0] = s_q.ien;
				default: begin
				end
			endcase
		end
	end

	// Status survives the watchdog's own reset so software sees cause
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge I_SYS_CLK);
	endclocking
	default disable iff (I_RESET);

	sequence s_reset_pulse;
		O_WD_RESET [*8];
	endsequence

	sequence s_back_to_default;
		!O_WD_RESET ##0 (s_q.ps == PS_RESET) ##0 (s_q.cnt == CNT_RESET);
	endsequence

	property p_default_after_reset;
		lnk.fire |=> s_reset_pulse ##1 s_back_to_default;
	endproperty
	a_default_after_reset: assert property (p_default_after_reset) // RQ1
		else $error("no default rate after reset pulse");

	property p_counts;
		running && lnk.tick && !wr && s_q.cnt != 8'hFF |=>
			s_q.cnt == 8'($past(s_q.cnt) + 8'h01);
	endproperty
	a_counts: assert property (p_counts) // RQ2
		else $error("counter did not advance on tick");

	property p_overflow;
		running && lnk.tick && s_q.cnt == 8'hFF |=> O_WD_RESET;
	endproperty
	a_overflow: assert property (p_overflow) // RQ3
		else $error("overflow without system reset");

	property p_good_key;
		wr && ofs == 3'h1 && key_ok && !lnk.busy |=> s_q.cnt == CNT_RESET;
	endproperty
	a_good_key: assert property (p_good_key) // RQ4
		else $error("correct key did not clear counter");

	property p_bad_key;
		wr && ofs == 3'h1 && !key_ok |=> O_WD_RESET && s_q.ist[IRQ_BADKEY];
	endproperty
	a_bad_key: assert property (p_bad_key) // RQ5
		else $error("wrong key did not reset");

	property p_bad_check;
		I_PSEL && I_PENABLE && I_PWRITE && I_PSTRB[0] && ofs == 3'h2 &&
			I_PWDATA[5:3] != 3'h5 |=> O_WD_RESET;
	endproperty
	a_bad_check: assert property (p_bad_check) // RQ6
		else $error("bad check bits did not reset");

	property p_disable_holds;
		s_q.dis && s_q.permit && !lnk.busy && !wr |=>
			$stable(s_q.cnt);
	endproperty
	a_disable_holds: assert property (p_disable_holds) // RQ7
		else $error("disabled watchdog still counts");

	property p_no_permit;
		!s_q.permit && !lnk.busy |-> running;
	endproperty
	a_no_permit: assert property (p_no_permit) // RQ8
		else $error("watchdog stopped without permit");

	property p_rate_kept;
		!wr && !lnk.busy |=> s_q.ps == $past(s_q.ps);
	endproperty
	a_rate_kept: assert property (p_rate_kept) // RQ9
		else $error("rate changed without a write");

	property p_upper_zero;
		I_PSEL && I_PENABLE |-> O_PRDATA[31:8] == 24'h00_0000;
	endproperty
	a_upper_zero: assert property (p_upper_zero) // RQ11
		else $error("upper read bytes not zero");
endmodule : wdtkr_top

`default_nettype wire
